// ---- src/capture_compare_pwm_unit.sv ----
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - One 16-bit register, role set by mode
// - Register built from low and high bytes
// - Capture/compare use timer one, modulation timer two
// - Pin routed to port B two or three
// - Special event resets timer one, starts conversion
// - Mode 1000 drives pin high on match
// - Mode 1001 drives pin low on match
// - Mode 1011 raises special event, pin unchanged
// - Modes 11xx select pulse width modulation
module capture_compare_pwm_unit #(
  parameter int unsigned T2_W = 8 // Timer two count width
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [cc_pkg::ADDR_W-1:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [cc_pkg::ADDR_W-1:0] i_araddr,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Timers and converter
  input wire logic [15:0] i_timer_one_count,
  input wire logic [T2_W-1:0] i_timer_two_count,
  input wire logic [1:0] i_timer_two_fine,
  input wire logic i_timer_two_period_match,
  input wire logic i_converter_enabled,
  output logic o_timer_one_reset,
  output logic o_conversion_start,
  // Pin routing and pins
  input wire logic i_pin_route_select,
  input wire logic i_port_b_pin_two,
  output logic o_port_b_pin_two,
  output logic o_port_b_pin_two_oe,
  input wire logic i_port_b_pin_three,
  output logic o_port_b_pin_three,
  output logic o_port_b_pin_three_oe,
  // Interrupt
  output logic o_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] control_ff; // Mode and duty low bits
  logic [15:0] unit_value_ff; // Capture/compare/duty register
  logic [cc_pkg::IRQ_W-1:0] irq_status_ff; // Sticky events
  logic [cc_pkg::IRQ_W-1:0] irq_enable_ff; // Event enables
  logic [cc_pkg::IRQ_W-1:0] irq_set; // Events this cycle
  logic [cc_pkg::IRQ_W-1:0] irq_clear; // Software clears
  logic irq_ff; // Interrupt output
  logic [3:0] mode; // Current mode select
  logic is_capture; // Capture modes
  logic is_compare; // Compare modes
  logic is_pwm; // Modulation modes
  logic pin_in; // Routed pin input
  logic pin_prev_ff; // Pin one cycle ago
  logic rise_edge; // Pin rose
  logic fall_edge; // Pin fell
  logic cap_edge; // Qualifying edge before prescale
  logic cap_fire; // Capture now
  logic match_now; // Timer one equals register
  logic match_prev_ff; // Match last cycle
  logic match_event; // Start of a match
  logic special_event; // Trigger event
  logic pin_level_ff; // Output latch
  logic pin_drive; // Unit drives the pin
  logic [T2_W+1:0] pwm_duty_ff; // Duty latched per period
  logic [T2_W+1:0] duty_now; // Duty from registers
  logic timer_one_reset_ff; // Registered trigger
  logic conversion_start_ff; // Registered trigger
  logic two_out_ff; // Port B two level
  logic two_oe_ff; // Port B two enable
  logic three_out_ff; // Port B three level
  logic three_oe_ff; // Port B three enable
  // Bus side
  logic aw_held_ff; // Write address taken
  logic w_held_ff; // Write data taken
  logic [cc_pkg::ADDR_W-1:0] awaddr_ff; // Held write address
  logic [7:0] wdata_ff; // Held write byte
  logic wlane_ff; // Held byte-lane enable
  logic bvalid_ff; // Write response pending
  logic [1:0] bresp_ff; // Write answer
  logic rvalid_ff; // Read data pending
  logic [31:0] rdata_ff; // Read data
  logic [1:0] rresp_ff; // Read answer
  logic wr_go; // Perform held write
  logic rd_go; // Take a read
  logic wr_hit; // Write address mapped
  logic [7:0] rd_byte; // Read mux result
  logic rd_hit; // Read address mapped

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign mode = control_ff[cc_pkg::MODE_LSB +: cc_pkg::MODE_W];
  // Capture uses modes 01xx
  assign is_capture = (mode[3:2] == 2'h1);
  assign is_compare = (mode[3:2] == 2'h2);
  assign is_pwm = (mode[3:2] == cc_pkg::MODE_PWM_TOP);

  // ----------------------------------------------------------------
  // Pin input and edges
  // ----------------------------------------------------------------
  // Route select high picks port B pin two
  assign pin_in = i_pin_route_select ? i_port_b_pin_two
                                     : i_port_b_pin_three;
  assign rise_edge = pin_in && !pin_prev_ff;
  assign fall_edge = !pin_in && pin_prev_ff;

  // Remember last pin level
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_in;
    end
  end

  // Falling edge for 0100, rising for the rest
  always_comb begin
    if (!is_capture) begin
      cap_edge = 1'b0;
    end else if (mode == cc_pkg::MODE_CAP_FALL) begin
      cap_edge = fall_edge;
    end else begin
      cap_edge = rise_edge;
    end
  end

  // Divides qualifying edges by 1, 4 or 16
  edge_prescaler u_prescaler (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_clear(!is_capture),
    .i_mode(mode),
    .i_edge(cap_edge),
    .o_fire(cap_fire)
  );

  // ----------------------------------------------------------------
  // Compare against timer one
  // ----------------------------------------------------------------
  assign match_now = is_compare
                  && (i_timer_one_count == unit_value_ff);
  // Timer may hold a value many cycles; act once
  assign match_event = match_now && !match_prev_ff;
  assign special_event = match_event
                      && (mode == cc_pkg::MODE_CMP_TRIG);

  // Match history
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= match_now;
    end
  end

  // Special event outputs, one-cycle pulses
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_one_reset_ff <= 1'b0;
      conversion_start_ff <= 1'b0;
    end else begin
      timer_one_reset_ff <= special_event;
      conversion_start_ff <= special_event
                          && i_converter_enabled;
    end
  end

  // ----------------------------------------------------------------
  // Modulation against timer two
  // ----------------------------------------------------------------
  // Upper bits from low byte, two lowest from control
  assign duty_now = {unit_value_ff[T2_W-1:0],
    control_ff[cc_pkg::DUTY_LSB +: cc_pkg::DUTY_LO_W]};

  // Duty reloads at each period start to avoid glitches
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwm_duty_ff <= '0;
    end else if (is_pwm && i_timer_two_period_match) begin
      pwm_duty_ff <= duty_now;
    end
  end

  // ----------------------------------------------------------------
  // Output latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_level_ff <= 1'b0;
    end else if (mode == cc_pkg::MODE_OFF) begin
      pin_level_ff <= 1'b0;
    end else if (is_pwm) begin
      if (i_timer_two_period_match) begin
        pin_level_ff <= (duty_now != '0);
      end else if ({i_timer_two_count, i_timer_two_fine}
                   == pwm_duty_ff) begin
        pin_level_ff <= 1'b0;
      end
    end else if (match_event && mode == cc_pkg::MODE_CMP_SET) begin
      pin_level_ff <= 1'b1;
    end else if (match_event && mode == cc_pkg::MODE_CMP_CLEAR) begin
      pin_level_ff <= 1'b0;
    end
  end

  // Drive in compare and modulation, listen in capture and off
  assign pin_drive = is_compare || is_pwm;

  // Registered pin levels to both pins, output enable on the routed pin only
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      two_out_ff <= 1'b0;
      two_oe_ff <= 1'b0;
      three_out_ff <= 1'b0;
      three_oe_ff <= 1'b0;
    end else begin
      two_out_ff <= pin_level_ff;
      three_out_ff <= pin_level_ff;
      two_oe_ff <= pin_drive && i_pin_route_select;
      three_oe_ff <= pin_drive && !i_pin_route_select;
    end
  end

  // ----------------------------------------------------------------
  // Unit value register
  // ----------------------------------------------------------------
  // Capture wins over a software write in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      unit_value_ff <= cc_pkg::VALUE_RESET;
    end else if (cap_fire) begin
      unit_value_ff <= i_timer_one_count;
    end else if (wr_go && wlane_ff) begin
      if (awaddr_ff == cc_pkg::ADDR_VALUE_LOW) begin
        unit_value_ff[7:0] <= wdata_ff;
      end else if (awaddr_ff == cc_pkg::ADDR_VALUE_HIGH) begin
        unit_value_ff[15:8] <= wdata_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control_ff <= cc_pkg::CONTROL_RESET;
    end else if (wr_go && wlane_ff
                 && awaddr_ff == cc_pkg::ADDR_CONTROL) begin
      control_ff <= wdata_ff & cc_pkg::CONTROL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[cc_pkg::IRQ_UNIT] = cap_fire || match_event;
    irq_set[cc_pkg::IRQ_SPECIAL] = special_event;
    irq_clear = '0;
    if (wr_go && wlane_ff && awaddr_ff == cc_pkg::ADDR_IRQ_CLEAR) begin
      irq_clear = wdata_ff[cc_pkg::IRQ_W-1:0];
    end
  end

  // Sticky flags, set beats clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_set;
    end
  end

  // Enable register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_enable_ff <= '0;
    end else if (wr_go && wlane_ff
                 && awaddr_ff == cc_pkg::ADDR_IRQ_ENABLE) begin
      irq_enable_ff <= wdata_ff[cc_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_enable_ff);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = (awaddr_ff == cc_pkg::ADDR_VALUE_LOW)
               || (awaddr_ff == cc_pkg::ADDR_VALUE_HIGH)
               || (awaddr_ff == cc_pkg::ADDR_CONTROL)
               || (awaddr_ff == cc_pkg::ADDR_IRQ_ENABLE)
               || (awaddr_ff == cc_pkg::ADDR_IRQ_CLEAR);

  // Address and data taken independently, held until used
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end else begin
        if (i_awvalid && !aw_held_ff) begin
          aw_held_ff <= 1'b1;
          awaddr_ff <= i_awaddr;
        end
        if (i_wvalid && !w_held_ff) begin
          w_held_ff <= 1'b1;
          wdata_ff <= i_wdata[7:0];
          wlane_ff <= i_wstrb[0];
        end
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= cc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? cc_pkg::RESP_OKAY : cc_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_go = i_arvalid && !rvalid_ff;

  // Read mux, upper bits zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (i_araddr)
      cc_pkg::ADDR_VALUE_LOW: begin
        rd_byte = unit_value_ff[7:0];
      end
      cc_pkg::ADDR_VALUE_HIGH: begin
        rd_byte = unit_value_ff[15:8];
      end
      cc_pkg::ADDR_CONTROL: begin
        rd_byte = control_ff;
      end
      cc_pkg::ADDR_IRQ_STATUS: begin
        rd_byte[cc_pkg::IRQ_W-1:0] = irq_status_ff;
      end
      cc_pkg::ADDR_IRQ_ENABLE: begin
        rd_byte[cc_pkg::IRQ_W-1:0] = irq_enable_ff;
      end
      cc_pkg::ADDR_IRQ_CLEAR: begin
        rd_byte = 8'h00; // Write-only
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data one cycle after address
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= cc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? cc_pkg::RESP_OKAY : cc_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_awready = !aw_held_ff;
  assign o_wready = !w_held_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = !rvalid_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_timer_one_reset = timer_one_reset_ff;
  assign o_conversion_start = conversion_start_ff;
  assign o_port_b_pin_two = two_out_ff;
  assign o_port_b_pin_two_oe = two_oe_ff;
  assign o_port_b_pin_three = three_out_ff;
  assign o_port_b_pin_three_oe = three_oe_ff;
  assign o_irq = irq_ff;
endmodule

// ---- src/cc_pkg.sv ----
package cc_pkg;
  // ----------------------------------------------------------------
  // Register map: indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
  localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
  localparam logic [7:0] IDX_CONTROL = 8'h17;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1a;
  localparam logic [7:0] ADDR_VALUE_LOW = 8'(IDX_VALUE_LOW * 4);
  localparam logic [7:0] ADDR_VALUE_HIGH = 8'(IDX_VALUE_HIGH * 4);
  localparam logic [7:0] ADDR_CONTROL = 8'(IDX_CONTROL * 4);
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'(IDX_IRQ_STATUS * 4);
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'(IDX_IRQ_ENABLE * 4);
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'(IDX_IRQ_CLEAR * 4);

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned DUTY_LSB = 4;
  localparam int unsigned DUTY_LO_W = 2;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Mode select encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_IRQ = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // ----------------------------------------------------------------
  // Capture prescaler terminal counts
  // ----------------------------------------------------------------
  localparam logic [3:0] PRESC_LAST_4 = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hf;

  // ----------------------------------------------------------------
  // Interrupt status bits and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_UNIT = 0;
  localparam int unsigned IRQ_SPECIAL = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/edge_prescaler.sv ----
`timescale 1ns/1ps
// Divides qualifying pin edges by 1, 4 or 16
module edge_prescaler (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control
  input wire logic i_clear,
  input wire logic [3:0] i_mode,
  // Edge in, capture strobe out
  input wire logic i_edge,
  output logic o_fire
);
  logic [3:0] count_ff; // Edges seen since last capture
  logic [3:0] last_count; // Terminal count for current mode

  // Pick terminal count from mode
  always_comb begin
    unique case (i_mode)
      cc_pkg::MODE_CAP_RISE4: begin
        last_count = cc_pkg::PRESC_LAST_4;
      end
      cc_pkg::MODE_CAP_RISE16: begin
        last_count = cc_pkg::PRESC_LAST_16;
      end
      default: begin
        last_count = 4'h0; // Every edge
      end
    endcase
  end

  assign o_fire = i_edge && (count_ff == last_count);

  // Edge counter, wraps at each capture
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_ff <= 4'h0;
    end else if (i_clear || o_fire) begin
      count_ff <= 4'h0;
    end else if (i_edge) begin
      count_ff <= count_ff + 4'h1;
    end
  end
endmodule

// ---- testbench/capture_compare_pwm_unit_tb.sv ----
`timescale 1ns/1ps
module capture_compare_pwm_unit_tb;
  // ------------------------------------------
  // Bench signals
  // ------------------------------------------
  logic clk, rst_b, awv, wv, br, arv, rr, hold, ld, ext, cv, route, pin;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic [15:0] ldv, v;
  logic [9:0] d;
  logic [3:0] m;
  logic [3:0] md [5] = '{4'h8, 4'ha, 4'hb, 4'hb, 4'h9};
  wire logic awr, wrdy, bv, arr, rv, t1r, cst, pm, irq, p2, p3, q2, q2e;
  wire logic q3, q3e;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat;
  wire logic [15:0] t1;
  wire logic [9:0] t2;
  int err_total = 0, n_checks = 0, cyc = 0, n_tr = 0, n_cs = 0, k, c, hi;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_tr <= n_tr + int'(t1r);
    n_cs <= n_cs + int'(cst);
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  capture_compare_pwm_unit u_dut (.i_clock(clk), .i_rst_b(rst_b),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv),
    .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat),
    .o_rresp(rresp), .i_timer_one_count(t1), .i_timer_two_count(t2[9:2]),
    .i_timer_two_fine(t2[1:0]), .i_timer_two_period_match(pm),
    .i_converter_enabled(cv), .o_timer_one_reset(t1r),
    .o_conversion_start(cst), .i_pin_route_select(route),
    .i_port_b_pin_two(p2), .o_port_b_pin_two(q2),
    .o_port_b_pin_two_oe(q2e), .i_port_b_pin_three(p3),
    .o_port_b_pin_three(q3), .o_port_b_pin_three_oe(q3e), .o_irq(irq));
  cc_far_side u_far (.i_clock(clk), .i_rst_b(rst_b), .i_hold(hold),
    .i_load(ld), .i_load_val(ldv), .i_t1_clr(t1r), .i_ext(ext),
    .i_two(q2), .i_two_oe(q2e), .i_three(q3), .i_three_oe(q3e),
    .o_t1(t1), .o_t2(t2), .o_pm(pm), .o_two(p2), .o_three(p3));
  // ------------------------------------------
  // Tasks and expectations
  // ------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv,
    input logic [1:0] er = 2'h0);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'($urandom), dv};
    br <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = 2'h0);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    chk(rdat, e);
    chk(32'(rresp), 32'(er));
  endtask
  // Pin pulses away from the idle level
  task automatic pulse(input int n);
    repeat (n) begin
      ext <= ~ext;
      repeat (3) @(posedge clk);
      ext <= ~ext;
      repeat (3) @(posedge clk);
    end
  endtask
  function automatic logic pin_for(logic [3:0] md_v, logic prev);
    if (md_v == cc_pkg::MODE_CMP_SET) return 1'b1;
    if (md_v == cc_pkg::MODE_CMP_CLEAR) return 1'b0;
    return prev;
  endfunction
  function automatic logic pwm_ok(int h, logic [9:0] duty);
    if (duty == 10'h000) return h == 0;
    return h == int'(duty) || h == int'(duty) + 1;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------
  // Test sequence
  // ------------------------------------------
  initial begin
    {rst_b, awv, wv, br, arv, rr, ld, ext, cv, route, pin} = '0;
    {awa, ara, wd, ldv} = '0;
    hold = 1'b1;
    void'($urandom(51));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(cc_pkg::ADDR_CONTROL, 32'h0);
    rd(cc_pkg::ADDR_IRQ_STATUS, 32'h0);
    rd(8'h00, 32'h0, cc_pkg::RESP_SLVERR);
    wr(8'h04, 8'h5a, cc_pkg::RESP_SLVERR);
    wr(cc_pkg::ADDR_CONTROL, 8'hf0);
    rd(cc_pkg::ADDR_CONTROL, 32'h30);
    v = 16'($urandom);
    wr(cc_pkg::ADDR_VALUE_LOW, v[7:0]);
    wr(cc_pkg::ADDR_VALUE_HIGH, v[15:8]);
    rd(cc_pkg::ADDR_VALUE_LOW, 32'(v[7:0]));
    rd(cc_pkg::ADDR_VALUE_HIGH, 32'(v[15:8]));
    $display("registers done");
    wr(cc_pkg::ADDR_IRQ_ENABLE, 8'h03);
    for (int i = 0; i < 5; i++) begin
      route <= i[0];
      cv <= i[0];
      ld <= 1'b1;
      ldv <= v - 16'h0004;
      wr(cc_pkg::ADDR_CONTROL, {4'h0, md[i]});
      ld <= 1'b0;
      hold <= 1'b0;
      k = n_tr;
      c = n_cs;
      repeat (20) @(posedge clk);
      hold <= 1'b1;
      pin = pin_for(md[i], pin);
      chk(32'(route ? p2 : p3), 32'(pin));
      chk(n_tr - k, 32'(md[i] == cc_pkg::MODE_CMP_TRIG));
      chk(n_cs - c, 32'(md[i] == 4'hb && cv));
      chk(32'(irq), 32'h1);
      rd(cc_pkg::ADDR_IRQ_STATUS, {md[i] == 4'hb, 1'b1});
      wr(cc_pkg::ADDR_IRQ_CLEAR, 8'h03);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
    end
    $display("compare done");
    wr(cc_pkg::ADDR_IRQ_ENABLE, 8'h00);
    for (int i = 4; i < 8; i++) begin
      m = 4'(i);
      ext <= (i != 4);
      route <= 1'($urandom);
      wr(cc_pkg::ADDR_CONTROL, 8'h00);
      wr(cc_pkg::ADDR_CONTROL, {4'h0, m});
      wr(cc_pkg::ADDR_VALUE_LOW, 8'h00);
      wr(cc_pkg::ADDR_VALUE_HIGH, 8'h00);
      wr(cc_pkg::ADDR_IRQ_CLEAR, 8'h03);
      v = 16'($urandom);
      ldv <= v;
      ld <= 1'b1;
      pulse((i < 6) ? 0 : (1 << (2 * (i - 5))) - 1);
      rd(cc_pkg::ADDR_VALUE_LOW, 32'h0);
      pulse(1);
      rd(cc_pkg::ADDR_VALUE_LOW, 32'(v[7:0]));
      rd(cc_pkg::ADDR_VALUE_HIGH, 32'(v[15:8]));
      rd(cc_pkg::ADDR_IRQ_STATUS, 32'h1);
      chk(32'(irq), 32'h0);
      ld <= 1'b0;
    end
    $display("capture done");
    for (int i = 0; i < 4; i++) begin
      m = {2'b11, 2'(i)};
      d = (i == 0) ? 10'h000 : 10'($urandom_range(4, 250));
      route <= i[0];
      wr(cc_pkg::ADDR_VALUE_LOW, d[9:2]);
      wr(cc_pkg::ADDR_CONTROL, {2'h0, d[1:0], m});
      rd(cc_pkg::ADDR_CONTROL, {26'h0, d[1:0], m});
      repeat (2) begin
        do @(posedge clk); while (!pm);
      end
      hi = 0;
      repeat (256) begin
        @(posedge clk);
        hi += int'(route ? p2 : p3);
      end
      chk(32'(pwm_ok(hi, d)), 32'h1);
    end
    $display("modulation done");
    print_verdict();
  end
endmodule

// ---- testbench/cc_far_side.sv ----
`timescale 1ns/1ps
// Timers and the pin's outside driver
module cc_far_side (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Bench control and unit drive
  input wire logic i_hold,
  input wire logic i_load,
  input wire logic [15:0] i_load_val,
  input wire logic i_t1_clr,
  input wire logic i_ext,
  input wire logic i_two,
  input wire logic i_two_oe,
  input wire logic i_three,
  input wire logic i_three_oe,
  // Timer values and pin levels
  output logic [15:0] o_t1,
  output logic [9:0] o_t2,
  output logic o_pm,
  output logic o_two,
  output logic o_three
);
  logic [15:0] t1_ff; // Timer one
  logic [9:0] t2_ff; // Timer two with fine bits
  // Timer one, cleared by the special event
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) t1_ff <= 16'h0000;
    else if (i_t1_clr) t1_ff <= 16'h0000;
    else if (i_load) t1_ff <= i_load_val;
    else if (!i_hold) t1_ff <= t1_ff + 16'h0001;
  end
  // Timer two, 256 clocks a period
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) t2_ff <= 10'h000;
    else t2_ff <= o_pm ? 10'h000 : t2_ff + 10'h001;
  end
  assign o_pm = t2_ff == 10'h0ff;
  assign o_t1 = t1_ff;
  assign o_t2 = t2_ff;
  // Released pin shows the outside level
  assign o_two = i_two_oe ? i_two : i_ext;
  assign o_three = i_three_oe ? i_three : i_ext;
endmodule

// ---- testbench/cc_unit_chk.sv ----
`timescale 1ns/1ps
// Port-level properties of the unit
module cc_unit_chk (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Watched ports
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic i_converter_enabled,
  input wire logic i_pin_route_select,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_timer_one_reset,
  input wire logic o_conversion_start,
  input wire logic o_port_b_pin_two_oe,
  input wire logic o_port_b_pin_three_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  event_pulse_a: assert property (
    o_timer_one_reset |=> !o_timer_one_reset) else $error("event too long");
  conv_pair_a: assert property (
    o_conversion_start |-> o_timer_one_reset) else $error("lone conversion");
  conv_gate_a: assert property (
    o_timer_one_reset && i_converter_enabled && $past(i_converter_enabled)
    |-> o_conversion_start) else $error("conversion missing");
  route_excl_a: assert property (
    !(o_port_b_pin_two_oe && o_port_b_pin_three_oe))
    else $error("both pins driven");
  route_sel_a: assert property (
    $stable(i_pin_route_select) && o_port_b_pin_two_oe
    |-> i_pin_route_select) else $error("wrong pin driven");
  wr_done_a: assert property (
    o_bvalid && i_bready |=> !o_bvalid) else $error("bvalid stuck");
  rd_done_a: assert property (
    o_rvalid && i_rready |=> !o_rvalid) else $error("rvalid stuck");
  rd_width_a: assert property (
    o_rvalid |-> o_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind capture_compare_pwm_unit cc_unit_chk u_chk (.i_clock(i_clock),
  .i_rst_b(i_rst_b), .i_bready(i_bready), .i_rready(i_rready),
  .i_converter_enabled(i_converter_enabled),
  .i_pin_route_select(i_pin_route_select), .o_bvalid(o_bvalid),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata),
  .o_timer_one_reset(o_timer_one_reset),
  .o_conversion_start(o_conversion_start),
  .o_port_b_pin_two_oe(o_port_b_pin_two_oe),
  .o_port_b_pin_three_oe(o_port_b_pin_three_oe));
